//--- shared/ssp_defines.svh
// Purpose: Named constants for the sync period negotiation block
// Assumes: Periods carried as 8-bit codes in 4 ns steps
// Notes:   Times in ns, cycle counts derived from the system clock
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_STEP_NS      4
`define SSP_CLK_NS       8
`define SSP_SYNC_MIN_NS  250
`define SSP_ASYNC_MIN_NS 667
`define SSP_ASYNC_CYC    ((`SSP_ASYNC_MIN_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_MIN_DIV      2
`define SSP_MAX_DIV      15
`define SSP_OSC_NS       125
`define SSP_CODE_W       8
`define SSP_CYC_W        8
`define SSP_CODE_ZERO    8'h00

`endif

//--- shared/ssp_pkg.sv
// Purpose: Types for the sync period negotiation block
// Assumes: Nothing beyond the defines header
// Notes:   Gray coded states along the usual path
package ssp_pkg;

   typedef enum logic [1:0] {
      SSP_IDLE  = 2'b00,
      SSP_OFFER = 2'b01,
      SSP_WAIT  = 2'b11,
      SSP_WRITE = 2'b10
   } ssp_state_t;

endpackage : ssp_pkg

//--- src/ssp_mem.sv
// Purpose: Per-target store of negotiated divisor, cycles and period
// Assumes: One write port, one read port, same clock
// Notes:   Registered read returns old data on a same-cycle write
`timescale 1ns/1ns
module ssp_mem #(
   parameter int W  = 20,
   parameter int AW = 3
) (
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   // Write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   // Read port
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [W-1:0]  rd_data
);

   logic [W-1:0] mem_r [0:(1<<AW)-1];
   logic [W-1:0] rd_data_r;
   logic [W-1:0] rd_data_nxt;

   always_comb begin
      rd_data_nxt = rd_data_r;
      if (rd_en) begin
         rd_data_nxt = mem_r[rd_addr];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
      if (!rst_n) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data = rd_data_r;

endmodule : ssp_mem

//--- src/ssp_neg.sv
// Purpose: Agrees a synchronous transfer period with each target
// Assumes: Target answers an offer with the same code or its own minimum
// Notes:   Achievable periods are integer divisions of the SCSI oscillator
//
// Notes on behaviour
// - Offered and answered periods are codes counting 4 ns steps.
// - Opening offer is the shortest period the adapter can sustain.
// - A counter-proposal is taken as agreed, with no further offer.
// - Later sync transfers never run shorter than the agreed period.
// - Negotiation starts on first connection with each target.
// - Unreachable agreed period uses the next longer producible period.
// - Periods are oscillator divisions; fastest divide two, then three.
// - Sync at most 4 MB/s, async at most 1.5 MB/s.
`timescale 1ns/1ns
`include "ssp_defines.svh"
module ssp_neg #(
   parameter int TGT_W         = 3,
   parameter int OSC_PERIOD_NS = `SSP_OSC_NS,
   parameter int MAX_DIV       = `SSP_MAX_DIV,
   parameter int DIV_W         = 4
) (
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   // Connection from the adapter's sequencer
   input  wire logic                     neg_en,
   input  wire logic                     conn_req,
   input  wire logic [TGT_W-1:0]         conn_tgt,
   // Offer to the target
   output logic                          offer_valid,
   output logic      [`SSP_CODE_W-1:0]   offer_period,
   input  wire logic                     offer_ready,
   // Answer from the target
   input  wire logic                     reply_valid,
   input  wire logic [`SSP_CODE_W-1:0]   reply_period,
   input  wire logic                     reply_reject,
   input  wire logic                     link_abort,
   // Negotiation status
   output logic                          neg_busy,
   output logic                          neg_done,
   output logic      [(1<<TGT_W)-1:0]    tgt_negotiated,
   // Transfer setting lookup
   input  wire logic                     xfer_req,
   input  wire logic [TGT_W-1:0]         xfer_tgt,
   output logic                          xfer_valid,
   output logic                          xfer_sync,
   output logic      [DIV_W-1:0]         xfer_div,
   output logic      [`SSP_CYC_W-1:0]    xfer_cyc,
   output logic      [`SSP_CODE_W-1:0]   xfer_period
);

   localparam int NUM_TGT = 1 << TGT_W;
   localparam int MW      = `SSP_CYC_W + DIV_W + `SSP_CODE_W;

   // Smallest producible divisor whose period reaches need_ns, else zero
   function automatic logic [DIV_W-1:0] div_for(input int need_ns);
      logic [DIV_W-1:0] d;
      d = '0;
      for (int i = MAX_DIV; i >= `SSP_MIN_DIV; i--) begin
         if (i * OSC_PERIOD_NS >= need_ns) begin
            d = DIV_W'(i);
         end
      end
      return d;
   endfunction : div_for

   function automatic logic [`SSP_CYC_W-1:0] cyc_for(input int d);
      int t;
      t = d * OSC_PERIOD_NS;
      return `SSP_CYC_W'((t + `SSP_CLK_NS - 1) / `SSP_CLK_NS);
   endfunction : cyc_for

   localparam logic [DIV_W-1:0] OFFER_DIV =
      div_for(`SSP_SYNC_MIN_NS);
   localparam logic [`SSP_CODE_W-1:0] OFFER_CODE =
      `SSP_CODE_W'((int'(OFFER_DIV) * OSC_PERIOD_NS) / `SSP_STEP_NS);
   localparam logic [`SSP_CYC_W-1:0] ASYNC_CYC =
      `SSP_CYC_W'(`SSP_ASYNC_CYC);

   generate
      if (MAX_DIV < `SSP_MIN_DIV || MAX_DIV >= (1 << DIV_W)) begin : g_bad_div
         $error("ssp_neg: MAX_DIV does not fit DIV_W or is below two");
      end
      if (OSC_PERIOD_NS * MAX_DIV < `SSP_SYNC_MIN_NS) begin : g_bad_osc
         $error("ssp_neg: no divisor reaches the sync minimum period");
      end
      if (OSC_PERIOD_NS * MAX_DIV / `SSP_STEP_NS > 255) begin : g_bad_code
         $error("ssp_neg: longest period overflows the period code");
      end
      if (OSC_PERIOD_NS * MAX_DIV / `SSP_CLK_NS > 255) begin : g_bad_cyc
         $error("ssp_neg: cycle count overflows its field");
      end
   endgenerate

   ssp_pkg::ssp_state_t       state_r, state_nxt;
   logic [TGT_W-1:0]          tgt_r, tgt_nxt;
   logic [`SSP_CODE_W-1:0]    offer_r, offer_nxt;
   logic [`SSP_CODE_W-1:0]    agreed_r, agreed_nxt;
   logic                      rej_r, rej_nxt;
   logic                      done_r, done_nxt;
   logic [NUM_TGT-1:0]        known_r, known_nxt;
   logic [NUM_TGT-1:0]        sync_r, sync_nxt;
   logic                      xv_r, xv_nxt;
   logic                      xk_r, xk_nxt;
   logic                      xs_r, xs_nxt;

   logic                      wr_en;
   logic [MW-1:0]             wr_data;
   logic [MW-1:0]             rd_data;
   int                        need_ns;
   logic [DIV_W-1:0]          w_div;
   logic                      w_sync;
   logic [`SSP_CYC_W-1:0]     w_cyc;

   // Transfer setting for the target being written
   always_comb begin
      need_ns = int'(agreed_r) * `SSP_STEP_NS;
      if (need_ns < `SSP_SYNC_MIN_NS) begin
         need_ns = `SSP_SYNC_MIN_NS;
      end
      w_div  = div_for(need_ns);
      w_sync = !rej_r && (w_div != '0);
      w_cyc  = w_sync ? cyc_for(int'(w_div)) : ASYNC_CYC;
   end

   always_comb begin
      state_nxt  = state_r;
      tgt_nxt    = tgt_r;
      offer_nxt  = offer_r;
      agreed_nxt = agreed_r;
      rej_nxt    = rej_r;
      done_nxt   = 1'b0;
      known_nxt  = known_r;
      sync_nxt   = sync_r;
      wr_en      = 1'b0;
      wr_data    = {w_cyc, w_div, agreed_r};
      case (state_r)
         ssp_pkg::SSP_IDLE: begin
            // First contact with a target opens negotiation
            if (conn_req && neg_en && !known_r[conn_tgt]) begin
               tgt_nxt   = conn_tgt;
               offer_nxt = OFFER_CODE;
               rej_nxt   = 1'b0;
               state_nxt = ssp_pkg::SSP_OFFER;
            end
         end
         ssp_pkg::SSP_OFFER: begin
            if (link_abort) begin
               state_nxt = ssp_pkg::SSP_IDLE;
            end else if (offer_ready) begin
               state_nxt = ssp_pkg::SSP_WAIT;
            end
         end
         ssp_pkg::SSP_WAIT: begin
            if (link_abort) begin
               state_nxt = ssp_pkg::SSP_IDLE;
            end else if (reply_reject) begin
               agreed_nxt = `SSP_CODE_ZERO;
               rej_nxt    = 1'b1;
               state_nxt  = ssp_pkg::SSP_WRITE;
            end else if (reply_valid) begin
               if (reply_period == offer_r) begin
                  agreed_nxt = offer_r;
               end else begin
                  agreed_nxt = reply_period;
               end
               state_nxt = ssp_pkg::SSP_WRITE;
            end
         end
         ssp_pkg::SSP_WRITE: begin
            wr_en          = 1'b1;
            known_nxt[tgt_r] = 1'b1;
            sync_nxt[tgt_r]  = w_sync;
            done_nxt       = 1'b1;
            state_nxt      = ssp_pkg::SSP_IDLE;
         end
         default: begin
            state_nxt = ssp_pkg::SSP_IDLE;
         end
      endcase
   end

   // Lookup: sync only once the target has been negotiated
   always_comb begin
      xv_nxt = xfer_req;
      xk_nxt = xk_r;
      xs_nxt = xs_r;
      if (xfer_req) begin
         xk_nxt = known_r[xfer_tgt];
         xs_nxt = known_r[xfer_tgt] && sync_r[xfer_tgt];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r  <= ssp_pkg::SSP_IDLE;
         tgt_r    <= '0;
         offer_r  <= `SSP_CODE_ZERO;
         agreed_r <= `SSP_CODE_ZERO;
         rej_r    <= 1'b0;
         done_r   <= 1'b0;
         known_r  <= '0;
         sync_r   <= '0;
         xv_r     <= 1'b0;
         xk_r     <= 1'b0;
         xs_r     <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         tgt_r    <= tgt_nxt;
         offer_r  <= offer_nxt;
         agreed_r <= agreed_nxt;
         rej_r    <= rej_nxt;
         done_r   <= done_nxt;
         known_r  <= known_nxt;
         sync_r   <= sync_nxt;
         xv_r     <= xv_nxt;
         xk_r     <= xk_nxt;
         xs_r     <= xs_nxt;
      end
   end

   ssp_mem #(
      .W  (MW),
      .AW (TGT_W)
   ) u_mem (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wr_en   (wr_en),
      .wr_addr (tgt_r),
      .wr_data (wr_data),
      .rd_en   (xfer_req),
      .rd_addr (xfer_tgt),
      .rd_data (rd_data)
   );

   assign offer_valid    = (state_r == ssp_pkg::SSP_OFFER);
   assign offer_period   = offer_r;
   assign neg_busy       = (state_r != ssp_pkg::SSP_IDLE);
   assign neg_done       = done_r;
   assign tgt_negotiated = known_r;
   assign xfer_valid     = xv_r;
   assign xfer_sync      = xs_r;
   // Unnegotiated targets run async at the async minimum cycle
   assign xfer_div       = xs_r ? rd_data[`SSP_CODE_W +: DIV_W] : '0;
   assign xfer_cyc       = xk_r ? rd_data[MW-1 -: `SSP_CYC_W] : ASYNC_CYC;
   assign xfer_period    = xs_r ? rd_data[`SSP_CODE_W-1:0] : `SSP_CODE_ZERO;

endmodule : ssp_neg

//--- bench/ssp_neg_chk.sv
// Purpose: Port level checks of the sync period negotiator
// Assumes: Offer default is the divide-by-two period, rounded down
// Notes:   Bound to every ssp_neg instance
`timescale 1ns/1ns
`include "ssp_defines.svh"
module ssp_neg_chk #(
   parameter int TGT_W = 3,
   parameter int DIV_W = 4
) (
   // Clock and reset
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   // Negotiation
   input wire logic                  neg_en,
   input wire logic                  conn_req,
   input wire logic [TGT_W-1:0]      conn_tgt,
   input wire logic                  offer_valid,
   input wire logic [7:0]            offer_period,
   input wire logic                  offer_ready,
   input wire logic                  reply_valid,
   input wire logic                  link_abort,
   input wire logic                  neg_busy,
   input wire logic                  neg_done,
   input wire logic [(1<<TGT_W)-1:0] tgt_negotiated,
   // Lookup
   input wire logic                  xfer_req,
   input wire logic [TGT_W-1:0]      xfer_tgt,
   input wire logic                  xfer_valid,
   input wire logic                  xfer_sync,
   input wire logic [DIV_W-1:0]      xfer_div,
   input wire logic [7:0]            xfer_cyc,
   input wire logic [7:0]            xfer_period
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_taken;
      offer_valid && offer_ready;
   endsequence
   sequence s_answer;
      reply_valid && !link_abort;
   endsequence
   offer_code_a : assert property (
      offer_valid |-> offer_period ==
      `SSP_MIN_DIV * `SSP_OSC_NS / `SSP_STEP_NS) else $error("bad offer");
   first_conn_a : assert property (
      conn_req && neg_en && !neg_busy && !tgt_negotiated[conn_tgt]
      |=> offer_valid) else $error("no offer");
   agree_end_a : assert property (
      s_taken ##1 s_answer |=> !offer_valid ##1 (neg_done && !offer_valid))
      else $error("no end");
   done_pulse_a : assert property (neg_done |=> !neg_done)
      else $error("done too long");
   look_ans_a : assert property (xfer_req |=> xfer_valid)
      else $error("no lookup answer");
   async_first_a : assert property (
      xfer_req && !tgt_negotiated[xfer_tgt] |=> !xfer_sync)
      else $error("sync before agreement");
   async_rate_a : assert property (
      xfer_valid && !xfer_sync |-> xfer_cyc == `SSP_ASYNC_CYC
      && xfer_div == 0 && xfer_period == 8'h00)
      else $error("bad async setting");
   sync_div_a : assert property (
      xfer_valid && xfer_sync |->
      xfer_div >= `SSP_MIN_DIV && xfer_div * `SSP_OSC_NS >= xfer_period * 4
      && (xfer_div == `SSP_MIN_DIV
      || (xfer_div - 1) * `SSP_OSC_NS < xfer_period * 4))
      else $error("bad divisor");
   sync_cyc_a : assert property (
      xfer_valid && xfer_sync |->
      xfer_cyc == (xfer_div * `SSP_OSC_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
      else $error("bad byte cycles");
endmodule : ssp_neg_chk

bind ssp_neg ssp_neg_chk #(.TGT_W(TGT_W), .DIV_W(DIV_W)) i_ssp_neg_chk (
   .clk_sys, .rst_n, .neg_en, .conn_req, .conn_tgt, .offer_valid,
   .offer_period, .offer_ready, .reply_valid, .link_abort, .neg_busy,
   .neg_done, .tgt_negotiated, .xfer_req, .xfer_tgt, .xfer_valid,
   .xfer_sync, .xfer_div, .xfer_cyc, .xfer_period);

//--- bench/ssp_tgt.sv
// Purpose: Behavioural SCSI target answering period offers
// Assumes: Offer held until taken, answer one cycle later
// Notes:   Idle answer code toggles so a stale code never looks valid
`timescale 1ns/1ns
module ssp_tgt (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Behaviour chosen by the bench
   input  wire logic [7:0] min_code,
   input  wire logic       refuse,
   input  wire logic [7:0] dly,
   // Link to the adapter
   input  wire logic       offer_valid,
   input  wire logic [7:0] offer_period,
   output logic            offer_ready,
   output logic            reply_valid,
   output logic [7:0]      reply_period,
   output logic            reply_reject
);
   logic [7:0] wait_cnt;
   always @(posedge clk_sys) begin
      reply_valid  <= rst_n && offer_valid && offer_ready && !refuse;
      reply_reject <= rst_n && offer_valid && offer_ready && refuse;
      if (!rst_n) begin
         reply_period <= 8'h00;
      end else if (offer_valid && offer_ready) begin
         // Echo if acceptable, else own minimum in 4 ns steps
         if (offer_period < min_code) begin
            reply_period <= min_code;
         end else begin
            reply_period <= offer_period;
         end
      end else begin
         reply_period <= ~reply_period;
      end
      if (!rst_n || !offer_valid || offer_ready) begin
         offer_ready <= 1'b0;
         wait_cnt    <= 8'h00;
      end else if (wait_cnt == dly) begin
         offer_ready <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 8'h01;
      end
   end
endmodule : ssp_tgt

//--- bench/scsi_sync_period_negotiation_bench.sv
// Purpose: Self-checking bench of the sync period negotiator
// Assumes: Default parameters, 125 ns oscillator
// Notes:   Inputs change by NBA at rising edges, checks 1 ns later
`timescale 1ns/1ns
module scsi_sync_period_negotiation_bench;
   logic clk_sys = 1'b0, rst_n = 1'b0, neg_en = 1'b1, conn_req = 1'b0;
   logic link_abort = 1'b0, xfer_req = 1'b0, refuse = 1'b0;
   logic [2:0] conn_tgt = 3'h0, xfer_tgt = 3'h0;
   logic [7:0] min_code = 8'h00, dly = 8'h00, offer_period, reply_period;
   logic offer_valid, offer_ready, reply_valid, reply_reject, neg_busy;
   logic neg_done, xfer_valid, xfer_sync;
   logic [7:0] tgt_negotiated, xfer_cyc, xfer_period;
   logic [3:0] xfer_div;
   int failures = 0, checks_done = 0;
   always #4 clk_sys = ~clk_sys;
   ssp_neg i_ssp_neg (.clk_sys, .rst_n, .neg_en, .conn_req, .conn_tgt,
      .offer_valid, .offer_period, .offer_ready, .reply_valid,
      .reply_period, .reply_reject, .link_abort, .neg_busy, .neg_done,
      .tgt_negotiated, .xfer_req, .xfer_tgt, .xfer_valid, .xfer_sync,
      .xfer_div, .xfer_cyc, .xfer_period);
   ssp_tgt i_ssp_tgt (.clk_sys, .rst_n, .min_code, .refuse, .dly,
      .offer_valid, .offer_period, .offer_ready, .reply_valid,
      .reply_period, .reply_reject);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic look(input logic [2:0] t, input logic [7:0] s, d, c, p);
      @(posedge clk_sys) xfer_tgt <= t;
      xfer_req <= 1'b1;
      @(posedge clk_sys) xfer_req <= 1'b0;
      #1 chk({7'h00, xfer_valid}, 8'h01);
      chk({7'h00, xfer_sync}, s);
      chk({4'h0, xfer_div}, d);
      chk(xfer_cyc, c);
      chk(xfer_period, p);
   endtask : look
   task automatic neg(input logic [2:0] t, input logic [7:0] m, input logic r);
      int n;
      @(posedge clk_sys) conn_tgt <= t;
      min_code <= m;
      refuse <= r;
      conn_req <= 1'b1;
      @(posedge clk_sys) conn_req <= 1'b0;
      for (n = 0; n < 40 && neg_done !== 1'b1; n++) @(posedge clk_sys) #1;
      chk({7'h00, neg_done}, 8'h01);
      chk({7'h00, tgt_negotiated[t]}, 8'h01);
   endtask : neg
   task automatic poke(input logic [2:0] t, input logic en);
      @(posedge clk_sys) conn_tgt <= t;
      neg_en <= en;
      conn_req <= 1'b1;
      @(posedge clk_sys) conn_req <= 1'b0;
      @(posedge clk_sys) #1 chk({7'h00, neg_busy}, 8'h00);
      neg_en <= 1'b1;
   endtask : poke
   task automatic t_reset;
      #1 chk(tgt_negotiated, 8'h00);
      look(3'h0, 8'h00, 8'h00, 8'h54, 8'h00);
      $display("reset done");
   endtask : t_reset
   task automatic t_echo;
      neg(3'h1, 8'h35, 1'b0);
      look(3'h1, 8'h01, 8'h02, 8'h20, 8'h3e);
      $display("echo done");
   endtask : t_echo
   task automatic t_counter;
      dly <= 8'h03;
      neg(3'h2, 8'h3f, 1'b0);
      look(3'h2, 8'h01, 8'h03, 8'h2f, 8'h3f);
      neg(3'h3, 8'hff, 1'b0);
      look(3'h3, 8'h01, 8'h09, 8'h8d, 8'hff);
      look(3'h1, 8'h01, 8'h02, 8'h20, 8'h3e);
      dly <= 8'h00;
      $display("counter done");
   endtask : t_counter
   task automatic t_refuse;
      neg(3'h4, 8'h35, 1'b1);
      look(3'h4, 8'h00, 8'h00, 8'h54, 8'h00);
      poke(3'h1, 1'b1);
      poke(3'h5, 1'b0);
      $display("refuse done");
   endtask : t_refuse
   task automatic t_abort;
      dly <= 8'h14;
      poke(3'h6, 1'b0);
      @(posedge clk_sys) conn_tgt <= 3'h6;
      conn_req <= 1'b1;
      @(posedge clk_sys) conn_req <= 1'b0;
      #1 chk({7'h00, offer_valid}, 8'h01);
      @(posedge clk_sys) link_abort <= 1'b1;
      @(posedge clk_sys) link_abort <= 1'b0;
      #1 chk({7'h00, neg_busy}, 8'h00);
      chk({7'h00, tgt_negotiated[6]}, 8'h00);
      dly <= 8'h00;
      $display("abort done");
   endtask : t_abort
   task automatic give_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (3000) @(posedge clk_sys);
      failures++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_echo();
      t_counter();
      t_refuse();
      t_abort();
      give_verdict();
   end
endmodule : scsi_sync_period_negotiation_bench
